//--- include/mts_map.svh
// Purpose: Offsets, fields, reset values and timing counts of the sequencer
// Assumes: 25 MHz clock, 32-bit register port
// Notes: Definitions only
`ifndef MTS_MAP_SVH
`define MTS_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MTS_OFS_CTRL 8'h00
`define MTS_OFS_STATUS 8'h04
`define MTS_OFS_SETTLE 8'h08
`define MTS_OFS_TO_FIRST 8'h0C
`define MTS_OFS_TO_NEXT 8'h10
`define MTS_OFS_TO_RCV 8'h14
`define MTS_OFS_TO_SRC 8'h18
`define MTS_OFS_SW_A 8'h1C
`define MTS_OFS_SW_B 8'h20
`define MTS_OFS_STEPS 8'h24
// ----------------------------------------
// Control fields
// ----------------------------------------
`define MTS_CTRL_GO 0
`define MTS_CTRL_SRC_LO 1
`define MTS_CTRL_SRC_HI 2
`define MTS_CTRL_PACE 3
`define MTS_CTRL_FREQ 4
`define MTS_CTRL_AUX1 5
`define MTS_CTRL_AUX2 6
`define MTS_CTRL_CLR 7
`define MTS_CTRL_STOP 8
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define MTS_SETTLE_US_RST 32'h0000_0002
`define MTS_TO_FIRST_US_RST 32'd15000000
`define MTS_TO_NEXT_US_RST 32'd10000000
`define MTS_TO_RCV_US_RST 32'd1000000
`define MTS_TO_SRC_US_RST 32'd1000000
`define MTS_CLK_MHZ 25
`define MTS_RCV_STB_NS 2000
`define MTS_SRC_STB_NS 12000
`define MTS_CLK_NS 40
`define MTS_RCV_STB_CYC ((`MTS_RCV_STB_NS) / (`MTS_CLK_NS))
`define MTS_SRC_STB_CYC ((`MTS_SRC_STB_NS) / (`MTS_CLK_NS))
`endif

//--- include/mts_pkg.sv
// Purpose: Types of the sequencer
// Assumes: Nothing
// Notes: Types only
package mts_pkg;
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_WSTART = 9'h002,
		ST_RSTB = 9'h004,
		ST_RWAIT = 9'h008,
		ST_SSTB = 9'h010,
		ST_SWAIT = 9'h020,
		ST_PACE = 9'h040,
		ST_SETTLE = 9'h080,
		ST_NEXT = 9'h100
	} mts_state_e;
	typedef logic [31:0] mts_word_t;
endpackage

//--- src/mts_pulse.sv
// Purpose: Fixed-width strobe generator
// Assumes: One clock
// Notes: Output is registered
`timescale 1ns/1ps
module mts_pulse #(
	parameter int WIDTH = 50
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic fire_i,
	output logic busy_o
);
	initial begin
		if (WIDTH < 1 || WIDTH > 65535) begin
			$error("mts_pulse width out of range");
		end
	end
	typedef struct packed {
		logic [15:0] cnt;
		logic busy;
	} mts_pulse_s;
	mts_pulse_s st_ff;
	mts_pulse_s nxt_st;
	always_comb begin
		nxt_st = st_ff;
		if (fire_i) begin
			nxt_st.cnt = 16'(WIDTH - 1);
			nxt_st.busy = 1'b1;
		end else if (st_ff.busy) begin
			if (st_ff.cnt == 16'h0000) begin
				nxt_st.busy = 1'b0;
			end else begin
				nxt_st.cnt = st_ff.cnt - 16'h0001;
			end
		end
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign busy_o = st_ff.busy;
endmodule

//--- src/mts_top.sv
// Purpose: Run-time measurement trigger sequencer
// Assumes: Synchronous inputs, 25 MHz clock
// Notes: Registers over a plain strobe port
//
// Behaviour
// - Run starts on host command, immediately, or on first external start pulse.
// - With external start, every start pulse arriving while waiting in ST_WSTART runs the whole sequence once.
// - After start, pulse receiver strobe then wait for receiver done.
// - On done, drive next switch entries, wait settle delay, strobe again.
// - Frequency change strobes both sources and waits for both done inputs.
// - Start pulses of 1 us to 1 ms width are accepted.
// - Receiver strobe width lies between 1 us and 3 us.
// - Settle delay is programmable and resets to 2 us.
// - Source strobe width lies between 10 us and 14 us.
// - Sequence-active output is high while a sequence runs.
// - Receiver sweep-halt may stand in for the done line.
// - Peer links carry sequence step signalling between controllers.
// - Two user TTL outputs follow the configuration, also during a run.
// - Two independent switch ports each carry their own entries.
// - Start wait times out, first 15 s, later 10 s, in microseconds.
// - Receiver done wait times out, default one second.
// - Source done wait times out, default one second.
// - Switch stepping is paced immediately or by peer triggers; immediate after reset.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "mts_map.svh"
module mts_top #(
	parameter int CLK_MHZ = `MTS_CLK_MHZ,
	parameter int ENTRIES = 8
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic sequence_start_pulse_i,
	output logic receiver_strobe_out_o,
	input wire logic receiver_done_in_i,
	input wire logic receiver_halt_i,
	output logic source_a_strobe_o,
	output logic source_b_strobe_o,
	input wire logic source_a_done_i,
	input wire logic source_b_done_i,
	output logic sequence_active_out_o,
	output logic [7:0] switch_port_a_o,
	output logic [7:0] switch_port_b_o,
	output logic peer_link_a_o,
	output logic peer_link_b_o,
	input wire logic peer_link_a_i,
	input wire logic peer_link_b_i,
	output logic aux1_o,
	output logic aux2_o
);
	initial begin
		if (ENTRIES < 1 || ENTRIES > 16 || CLK_MHZ < 1 || CLK_MHZ > 255) begin
			$error("mts_top parameters out of range");
		end
	end
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		mts_pkg::mts_state_e fsm;
		logic [1:0] start_src;
		logic pace_peer;
		logic freq;
		logic aux1;
		logic aux2;
		logic err;
		logic run_first;
		logic [31:0] settle_us;
		logic [31:0] to_first;
		logic [31:0] to_next;
		logic [31:0] to_rcv;
		logic [31:0] to_src;
		logic [3:0] steps;
		logic [3:0] idx;
		logic [ENTRIES-1:0][7:0] tab_a;
		logic [ENTRIES-1:0][7:0] tab_b;
		logic [31:0] us_cnt;
		logic [7:0] div;
		logic start_d;
		logic peer_d;
		logic done_d;
		logic a_seen;
		logic b_seen;
		logic [7:0] sw_a;
		logic [7:0] sw_b;
		logic active;
		logic link_a;
		logic link_b;
		logic [31:0] rdata;
	} mts_top_s;
	mts_top_s st_ff;
	mts_top_s nxt_st;
	logic rcv_fire;
	logic src_fire;
	logic rcv_busy;
	logic src_busy;
	logic tick;
	logic start_edge;
	logic peer_edge;
	logic rcv_done;
	logic done_edge;

	function automatic logic expired(input logic [31:0] cnt, input logic [31:0] lim);
		expired = (cnt >= lim);
	endfunction

	// ----------------------------------------
	// Strobe generators
	// ----------------------------------------
	mts_pulse #(.WIDTH(`MTS_RCV_STB_CYC)) u_rcv_pulse (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.fire_i(rcv_fire),
		.busy_o(rcv_busy)
	);
	mts_pulse #(.WIDTH(`MTS_SRC_STB_CYC)) u_src_pulse (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.fire_i(src_fire),
		.busy_o(src_busy)
	);

	assign tick = (st_ff.div == 8'(CLK_MHZ - 1));
	assign start_edge = sequence_start_pulse_i && !st_ff.start_d;
	assign peer_edge = (peer_link_a_i || peer_link_b_i) && !st_ff.peer_d;
	assign rcv_done = receiver_done_in_i || receiver_halt_i;
	assign done_edge = rcv_done && !st_ff.done_d;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		rcv_fire = 1'b0;
		src_fire = 1'b0;
		nxt_st.start_d = sequence_start_pulse_i;
		nxt_st.peer_d = peer_link_a_i || peer_link_b_i;
		nxt_st.done_d = rcv_done;
		nxt_st.div = tick ? 8'h00 : st_ff.div + 8'h01;
		if (tick) begin
			nxt_st.us_cnt = st_ff.us_cnt + 32'h0000_0001;
		end
		nxt_st.rdata = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				`MTS_OFS_CTRL: nxt_st.rdata = {23'h0, 1'b0, 1'b0, st_ff.aux2, st_ff.aux1, st_ff.freq,
					st_ff.pace_peer, st_ff.start_src, 1'b0};
				`MTS_OFS_STATUS: nxt_st.rdata = {26'h0, st_ff.idx, st_ff.err, st_ff.active};
				`MTS_OFS_SETTLE: nxt_st.rdata = st_ff.settle_us;
				`MTS_OFS_TO_FIRST: nxt_st.rdata = st_ff.to_first;
				`MTS_OFS_TO_NEXT: nxt_st.rdata = st_ff.to_next;
				`MTS_OFS_TO_RCV: nxt_st.rdata = st_ff.to_rcv;
				`MTS_OFS_TO_SRC: nxt_st.rdata = st_ff.to_src;
				`MTS_OFS_STEPS: nxt_st.rdata = {28'h0, st_ff.steps};
				default: nxt_st.rdata = 32'h0000_0000;
			endcase
		end
		if (wr_i) begin
			case (addr_i)
				`MTS_OFS_CTRL: begin
					nxt_st.start_src = wdata_i[`MTS_CTRL_SRC_HI:`MTS_CTRL_SRC_LO];
					nxt_st.pace_peer = wdata_i[`MTS_CTRL_PACE];
					nxt_st.freq = wdata_i[`MTS_CTRL_FREQ];
					nxt_st.aux1 = wdata_i[`MTS_CTRL_AUX1];
					nxt_st.aux2 = wdata_i[`MTS_CTRL_AUX2];
					if (wdata_i[`MTS_CTRL_CLR]) begin
						nxt_st.err = 1'b0;
					end
				end
				`MTS_OFS_SETTLE: nxt_st.settle_us = wdata_i;
				`MTS_OFS_TO_FIRST: nxt_st.to_first = wdata_i;
				`MTS_OFS_TO_NEXT: nxt_st.to_next = wdata_i;
				`MTS_OFS_TO_RCV: nxt_st.to_rcv = wdata_i;
				`MTS_OFS_TO_SRC: nxt_st.to_src = wdata_i;
				`MTS_OFS_SW_A: nxt_st.tab_a[wdata_i[11:8] % 4'(ENTRIES)] = wdata_i[7:0];
				`MTS_OFS_SW_B: nxt_st.tab_b[wdata_i[11:8] % 4'(ENTRIES)] = wdata_i[7:0];
				`MTS_OFS_STEPS: nxt_st.steps = wdata_i[3:0];
				default: ;
			endcase
		end
		case (st_ff.fsm)
			mts_pkg::ST_IDLE: begin
				nxt_st.active = 1'b0;
				if (wr_i && addr_i == `MTS_OFS_CTRL && wdata_i[`MTS_CTRL_GO]) begin
					nxt_st.run_first = 1'b1;
					nxt_st.us_cnt = 32'h0;
					nxt_st.fsm = (wdata_i[`MTS_CTRL_SRC_HI:`MTS_CTRL_SRC_LO] == 2'h2) ? mts_pkg::ST_WSTART
						: mts_pkg::ST_RSTB;
				end else if (st_ff.start_src == 2'h1) begin
					nxt_st.fsm = mts_pkg::ST_RSTB;
				end
			end
			mts_pkg::ST_WSTART: begin
				nxt_st.active = 1'b0;
				if (start_edge) begin
					nxt_st.run_first = 1'b0;
					nxt_st.fsm = mts_pkg::ST_RSTB;
				end else if (expired(st_ff.us_cnt, st_ff.run_first ? st_ff.to_first : st_ff.to_next)) begin
					nxt_st.err = 1'b1;
					nxt_st.fsm = mts_pkg::ST_IDLE;
				end
			end
			mts_pkg::ST_RSTB: begin
				nxt_st.active = 1'b1;
				nxt_st.idx = 4'h0;
				nxt_st.sw_a = st_ff.tab_a[0];
				nxt_st.sw_b = st_ff.tab_b[0];
				nxt_st.link_a = 1'b1;
				rcv_fire = 1'b1;
				nxt_st.us_cnt = 32'h0;
				nxt_st.fsm = mts_pkg::ST_RWAIT;
			end
			mts_pkg::ST_RWAIT: begin
				if (!rcv_busy) begin
					nxt_st.link_a = 1'b0;
				end
				if (!rcv_busy && done_edge) begin
					nxt_st.us_cnt = 32'h0;
					if (st_ff.idx + 4'h1 >= st_ff.steps) begin
						nxt_st.fsm = mts_pkg::ST_NEXT;
					end else if (st_ff.freq) begin
						src_fire = 1'b1;
						nxt_st.a_seen = 1'b0;
						nxt_st.b_seen = 1'b0;
						nxt_st.fsm = mts_pkg::ST_SSTB;
					end else begin
						nxt_st.fsm = mts_pkg::ST_PACE;
					end
				end else if (expired(st_ff.us_cnt, st_ff.to_rcv)) begin
					nxt_st.err = 1'b1;
					nxt_st.fsm = mts_pkg::ST_IDLE;
				end
			end
			mts_pkg::ST_SSTB: begin
				if (!src_busy) begin
					nxt_st.fsm = mts_pkg::ST_SWAIT;
				end
			end
			mts_pkg::ST_SWAIT: begin
				nxt_st.a_seen = st_ff.a_seen || source_a_done_i;
				nxt_st.b_seen = st_ff.b_seen || source_b_done_i;
				if (nxt_st.a_seen && nxt_st.b_seen) begin
					nxt_st.fsm = mts_pkg::ST_PACE;
				end else if (expired(st_ff.us_cnt, st_ff.to_src)) begin
					nxt_st.err = 1'b1;
					nxt_st.fsm = mts_pkg::ST_IDLE;
				end
			end
			mts_pkg::ST_PACE: begin
				nxt_st.link_b = 1'b1;
				if (!st_ff.pace_peer || peer_edge) begin
					nxt_st.idx = st_ff.idx + 4'h1;
					nxt_st.sw_a = st_ff.tab_a[(st_ff.idx + 4'h1) % 4'(ENTRIES)];
					nxt_st.sw_b = st_ff.tab_b[(st_ff.idx + 4'h1) % 4'(ENTRIES)];
					nxt_st.us_cnt = 32'h0;
					nxt_st.div = 8'h00;
					nxt_st.fsm = mts_pkg::ST_SETTLE;
				end
			end
			mts_pkg::ST_SETTLE: begin
				nxt_st.link_b = 1'b0;
				if (expired(st_ff.us_cnt, st_ff.settle_us)) begin
					rcv_fire = 1'b1;
					nxt_st.us_cnt = 32'h0;
					nxt_st.fsm = mts_pkg::ST_RWAIT;
				end
			end
			mts_pkg::ST_NEXT: begin
				nxt_st.active = 1'b0;
				nxt_st.us_cnt = 32'h0;
				nxt_st.fsm = (st_ff.start_src == 2'h2) ? mts_pkg::ST_WSTART : mts_pkg::ST_IDLE;
			end
			default: nxt_st.fsm = mts_pkg::ST_IDLE;
		endcase
		if (nxt_st.fsm == mts_pkg::ST_IDLE) begin
			nxt_st.active = 1'b0;
			nxt_st.link_a = 1'b0;
			nxt_st.link_b = 1'b0;
		end
		if (wr_i && addr_i == `MTS_OFS_CTRL && wdata_i[`MTS_CTRL_STOP]) begin
			nxt_st.fsm = mts_pkg::ST_IDLE;
			nxt_st.active = 1'b0;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_ff <= '0;
			st_ff.fsm <= mts_pkg::ST_IDLE;
			st_ff.settle_us <= `MTS_SETTLE_US_RST;
			st_ff.to_first <= `MTS_TO_FIRST_US_RST;
			st_ff.to_next <= `MTS_TO_NEXT_US_RST;
			st_ff.to_rcv <= `MTS_TO_RCV_US_RST;
			st_ff.to_src <= `MTS_TO_SRC_US_RST;
			st_ff.steps <= 4'h1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata_o = st_ff.rdata;
	assign receiver_strobe_out_o = rcv_busy;
	assign source_a_strobe_o = src_busy;
	assign source_b_strobe_o = src_busy;
	assign sequence_active_out_o = st_ff.active;
	assign switch_port_a_o = st_ff.sw_a;
	assign switch_port_b_o = st_ff.sw_b;
	assign peer_link_a_o = st_ff.link_a;
	assign peer_link_b_o = st_ff.link_b;
	assign aux1_o = st_ff.aux1;
	assign aux2_o = st_ff.aux2;
endmodule

//--- sim/mts_top_props.sv
// Purpose: Port assertions of the sequencer
// Assumes: One clock, strobes active high
// Notes: Bound to mts_top
`timescale 1ns/1ps
module mts_top_props #(
	parameter int CLK_MHZ = 25
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic receiver_strobe_out_o,
	input wire logic receiver_done_in_i,
	input wire logic receiver_halt_i,
	input wire logic source_a_strobe_o,
	input wire logic source_b_strobe_o,
	input wire logic sequence_active_out_o,
	input wire logic [7:0] switch_port_a_o,
	input wire logic [7:0] switch_port_b_o,
	input wire logic aux1_o,
	input wire logic aux2_o
);
	// ----
	// Helpers and checks
	// ----
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	int rc, sc, pc, st;
	logic ds, x1, x2;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rc <= 0;
			sc <= 0;
			pc <= 0;
			st <= 2;
			ds <= 1'h0;
			x1 <= 1'h0;
			x2 <= 1'h0;
		end else begin
			rc <= receiver_strobe_out_o ? rc + 1 : 0;
			sc <= source_a_strobe_o ? sc + 1 : 0;
			pc <= $changed({switch_port_a_o, switch_port_b_o}) ? 1 : pc + 1;
			st <= (wr_i && addr_i == 8'h08) ? int'(wdata_i) : st;
			ds <= $rose(receiver_strobe_out_o) ? 1'h0 :
				(!receiver_strobe_out_o && $rose(receiver_done_in_i || receiver_halt_i)) ? 1'h1 : ds;
			x1 <= (wr_i && addr_i == 8'h00) ? wdata_i[5] : x1;
			x2 <= (wr_i && addr_i == 8'h00) ? wdata_i[6] : x2;
		end
	end
	a_rx_max: assert property (receiver_strobe_out_o |-> rc < 3 * CLK_MHZ)
		else $error("rx strobe too long");
	a_rx_min: assert property ($fell(receiver_strobe_out_o) |-> rc >= CLK_MHZ)
		else $error("rx strobe too short");
	a_src_max: assert property (source_a_strobe_o |-> sc < 14 * CLK_MHZ)
		else $error("src strobe too long");
	a_src_min: assert property ($fell(source_a_strobe_o) |-> sc >= 10 * CLK_MHZ)
		else $error("src strobe too short");
	a_src_pair: assert property (source_a_strobe_o == source_b_strobe_o)
		else $error("src strobes differ");
	a_src_after: assert property ($rose(source_a_strobe_o) |-> ds && !receiver_strobe_out_o)
		else $error("src strobe before rx done");
	a_strb_active: assert property ((receiver_strobe_out_o || source_a_strobe_o) |-> sequence_active_out_o)
		else $error("strobe while inactive");
	a_ports_hold: assert property (receiver_strobe_out_o && $past(receiver_strobe_out_o) |-> $stable({switch_port_a_o, switch_port_b_o}))
		else $error("ports moved in strobe");
	a_settle_min: assert property ($rose(receiver_strobe_out_o) && !$changed(switch_port_a_o) |-> pc >= st * CLK_MHZ)
		else $error("settle too short");
	a_aux_follow: assert property (wr_i && addr_i == 8'h00 |-> ##[1:2] (aux1_o == x1 && aux2_o == x2))
		else $error("aux not following");
	a_reset_quiet: assert property ($rose(arst_n_i) |-> !receiver_strobe_out_o && !source_a_strobe_o && !sequence_active_out_o)
		else $error("busy after reset");
	c_src: cover property ($rose(source_a_strobe_o));
	c_end: cover property ($fell(sequence_active_out_o));
	c_settle: cover property ($rose(receiver_strobe_out_o) && !$changed(switch_port_a_o) && pc > 1);
endmodule
bind mts_top mts_top_props #(.CLK_MHZ(CLK_MHZ)) u_props (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i,
	.receiver_strobe_out_o, .receiver_done_in_i, .receiver_halt_i, .source_a_strobe_o, .source_b_strobe_o,
	.sequence_active_out_o, .switch_port_a_o, .switch_port_b_o, .aux1_o, .aux2_o);

//--- sim/mts_partner.sv
// Purpose: Receiver and source model facing the sequencer
// Assumes: Strobes are active-high pulses
// Notes: Answers follow the falling edge of each strobe
`timescale 1ns/1ps
module mts_partner (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic rx_stb_i,
	input wire logic sa_stb_i,
	input wire logic sb_stb_i,
	input wire logic mute_i,
	input wire logic use_halt_i,
	output logic done_o,
	output logic halt_o,
	output logic sa_done_o,
	output logic sb_done_o
);
	// ----
	// Answer timers
	// ----
	logic [2:0] prev;
	int rc, ac, bc;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev <= 3'h0;
			rc <= 0;
			ac <= 0;
			bc <= 0;
		end else begin
			prev <= {rx_stb_i, sa_stb_i, sb_stb_i};
			rc <= (prev[2] && !rx_stb_i && !mute_i) ? 40 : (rc > 0 ? rc - 1 : 0);
			ac <= (prev[1] && !sa_stb_i) ? 60 : (ac > 0 ? ac - 1 : 0);
			bc <= (prev[0] && !sb_stb_i) ? 90 : (bc > 0 ? bc - 1 : 0);
		end
	end
	assign done_o = !use_halt_i && rc inside {[1:3]};
	assign halt_o = use_halt_i && rc inside {[1:3]};
	assign sa_done_o = ac inside {[1:25]};
	assign sb_done_o = bc inside {[1:25]};
endmodule

//--- sim/tb_mts_top.sv
// Purpose: Self-checking bench of the sequencer
// Assumes: Partner model answers every strobe except receiver strobes under mute
// Notes: Timeouts shortened by register writes
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_total++; \
	$display("wrong value %s exp %0h got %0h", n, e, a); end end
module tb_mts_top;
	// ----
	// Bench
	// ----
	logic clk_i = 1'h0;
	logic arst_n_i = 1'h0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic wr_i = 1'h0, rd_i = 1'h0, start = 1'h0, peer_a = 1'h0, peer_b = 1'h0, mute = 1'h0, hlt = 1'h0;
	logic [31:0] rdata_o, d;
	logic rx, done, halt, sa, sb, sad, sbd, act, pla, plb, aux1, aux2, q;
	logic [7:0] pa, pb;
	int err_total = 0;
	int num_checks = 0;
	int w, n;
	always #20 clk_i = ~clk_i;
	mts_top DUT (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sequence_start_pulse_i(start),
		.receiver_strobe_out_o(rx), .receiver_done_in_i(done), .receiver_halt_i(halt), .source_a_strobe_o(sa),
		.source_b_strobe_o(sb), .source_a_done_i(sad), .source_b_done_i(sbd), .sequence_active_out_o(act),
		.switch_port_a_o(pa), .switch_port_b_o(pb), .peer_link_a_o(pla), .peer_link_b_o(plb),
		.peer_link_a_i(peer_a), .peer_link_b_i(peer_b), .aux1_o(aux1), .aux2_o(aux2));
	mts_partner PARTNER (.clk_i, .arst_n_i, .rx_stb_i(rx), .sa_stb_i(sa), .sb_stb_i(sb), .mute_i(mute),
		.use_halt_i(hlt), .done_o(done), .halt_o(halt), .sa_done_o(sad), .sb_done_o(sbd));
	function automatic logic sg(input int s);
		return s == 0 ? rx : (s == 1 ? act : sa);
	endfunction
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wt(input int s, input logic v, input int lim);
		for (int i = 0; i < lim; i++) begin
			@(posedge clk_i);
			#1;
			if (sg(s) === v) return;
		end
		err_total++;
		$display("wrong value wait %0d exp %0h got none", s, v);
		stop_test();
	endtask
	task automatic width(input int s, output int c);
		wt(s, 1'h1, 3000);
		c = 0;
		while (sg(s) === 1'h1 && c < 1000) begin
			@(posedge clk_i);
			#1;
			c++;
		end
		if (c >= 1000) begin
			err_total++;
			$display("wrong value width %0d exp low got high", s);
			stop_test();
		end
	endtask
	task automatic gap(output int c);
		c = 0;
		while (rx !== 1'h1 && c < 3000) begin
			@(posedge clk_i);
			#1;
			c++;
		end
		if (c >= 3000) begin
			err_total++;
			$display("wrong value gap exp strobe got none");
			stop_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'h1;
		@(posedge clk_i);
		wr_i <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge clk_i);
		rd_i <= 1'h0;
		#1;
		d = rdata_o;
	endtask
	task automatic t_reset();
		logic [7:0] ad [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h24, 8'h3C};
		logic [31:0] ex [8] = '{32'h0, 32'h2, 32'h00E4_E1C0, 32'h0098_9680, 32'h000F_4240, 32'h000F_4240, 32'h1, 32'h0};
		`CHK("idle", 20'h00000, {rx, sa, sb, act, pa, pb})
		for (int i = 0; i < 8; i++) begin
			rd(ad[i]);
			`CHK("reg", ex[i], d)
		end
	endtask
	task automatic t_host();
		wr(8'h1C, 32'h0000_0041);
		wr(8'h1C, 32'h0000_0182);
		wr(8'h20, 32'h0000_00C3);
		wr(8'h20, 32'h0000_0105);
		wr(8'h24, 32'h0000_0002);
		wr(8'h00, 32'h0000_0021);
		width(0, w);
		`CHK("rx width", 1'h1, w >= 25 && w <= 75)
		`CHK("ports0 act aux", 19'h2_0E1E, {pa, pb, act, aux1, aux2})
		gap(n);
		`CHK("settle gap", 1'h1, n >= 85)
		`CHK("ports1", 16'h8205, {pa, pb})
		width(0, w);
		wt(1, 1'h0, 200);
	endtask
	task automatic t_halt();
		hlt <= 1'h1;
		wr(8'h00, 32'h0000_0001);
		width(0, w);
		width(0, w);
		wt(1, 1'h0, 200);
		rd(8'h04);
		`CHK("halt err", 1'h0, d[1])
		hlt <= 1'h0;
	endtask
	task automatic t_freq();
		wr(8'h00, 32'h0000_0011);
		width(0, w);
		width(2, w);
		`CHK("src width", 1'h1, w >= 250 && w <= 350)
		gap(n);
		`CHK("src wait", 1'h1, n >= 115)
		wt(1, 1'h0, 400);
	endtask
	task automatic t_pace();
		wr(8'h00, 32'h0000_0009);
		width(0, w);
		`CHK("link a", 1'h1, pla)
		fork
			gap(n);
			begin
				repeat (300) @(posedge clk_i);
				`CHK("link b", 1'h1, plb)
				peer_a <= 1'h1;
				repeat (25) @(posedge clk_i);
				peer_a <= 1'h0;
			end
		join
		`CHK("peer pace", 1'h1, n >= 300 && pa === 8'h82)
		wt(1, 1'h0, 400);
	endtask
	task automatic t_timeout();
		mute <= 1'h1;
		wr(8'h14, 32'h0000_0005);
		wr(8'h00, 32'h0000_0001);
		wt(1, 1'h0, 400);
		rd(8'h04);
		`CHK("rcv timeout", 2'h2, d[1:0])
		wr(8'h00, 32'h0000_0080);
		rd(8'h04);
		`CHK("err clear", 1'h0, d[1])
		mute <= 1'h0;
	endtask
	task automatic t_imm();
		wr(8'h00, 32'h0000_0002);
		width(0, w);
		`CHK("imm width", 32'd50, w)
		wr(8'h00, 32'h0000_0000);
		wt(1, 1'h0, 400);
		rd(8'h04);
		`CHK("imm err", 2'h0, d[1:0])
	endtask
	task automatic t_ext();
		wr(8'h24, 32'h0000_0001);
		wr(8'h10, 32'h0000_0014);
		wr(8'h00, 32'h0000_0005);
		for (int p = 0; p < 2; p++) begin
			n = 0;
			start <= 1'h1;
			for (int i = 0; i < (p ? 25000 : 25) + 200; i++) begin
				q = rx;
				@(posedge clk_i);
				if (i == (p ? 25000 : 25) - 1) start <= 1'h0;
				#1;
				if (rx === 1'h1 && q !== 1'h1) n++;
			end
			`CHK("runs", 32'h0000_0001, n)
		end
		rd(8'h04);
		`CHK("start timeout", 2'h2, d[1:0])
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'h1;
		t_reset();
		t_host();
		t_halt();
		t_freq();
		t_pace();
		t_timeout();
		t_imm();
		t_ext();
		stop_test();
	end
endmodule
